// [logic/video_output_cfg.sv]
// AXI4-Lite register bank for video output mode, swing and loop-through steering.
// Behaviour
// - Bit 7 reads sampled strap level
// - Bit 6 override enable, resets zero
// - Bit 5 gives colour mapping when overridden
// - Output mode field decodes four modes
// - Output mode loaded from strap on first cycle after reset release
// - Two-bit swing setting, resets zero
// - Enable bit gates loop-through driver
`timescale 1ns/100ps
`default_nettype none

module video_output_cfg
(
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic [11:0]                s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output var  logic                       s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output var  logic                       s_axi_wready,
	output var  logic [1:0]                 s_axi_bresp,
	output var  logic                       s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [11:0]                s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output var  logic                       s_axi_arready,
	output var  logic [31:0]                s_axi_rdata,
	output var  logic [1:0]                 s_axi_rresp,
	output var  logic                       s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	input  wire logic                       strap_select_pin,
	input  wire logic [1:0]                 strap_mode_pins,
	input  wire logic                       receive_input_zero,
	input  wire logic                       receive_input_one,
	output var  video_cfg_pkg::video_ctrl_t video_ctrl,
	output var  logic                       loopthrough_output
);

	// ****************************************************************
	// Register state.
	// ****************************************************************
	logic                              strap_r,     strap_nxt;
	logic                              ovr_r,       ovr_nxt;
	logic                              mapreg_r,    mapreg_nxt;
	video_cfg_pkg::video_output_mode_t mode_r,      mode_nxt;
	logic [1:0]                        swing_r,     swing_nxt;
	logic                              sela_r,      sela_nxt;
	logic                              drv_r,       drv_nxt;
	logic [1:0]                        selb_r,      selb_nxt;
	logic                              load_r,      load_nxt;
	video_cfg_pkg::video_ctrl_t        ctrl_r,      ctrl_nxt;

	// ****************************************************************
	// Bus channel state.
	// ****************************************************************
	logic        aw_have_r, aw_have_nxt;
	logic [9:0]  aw_idx_r,  aw_idx_nxt;
	logic        w_have_r,  w_have_nxt;
	logic [7:0]  w_data_r,  w_data_nxt;
	logic        w_lane_r,  w_lane_nxt;
	logic        bvalid_r,  bvalid_nxt;
	logic [1:0]  bresp_r,   bresp_nxt;
	logic        rvalid_r,  rvalid_nxt;
	logic [31:0] rdata_r,   rdata_nxt;
	logic [1:0]  rresp_r,   rresp_nxt;
	logic        awready_r, awready_nxt;
	logic        wready_r,  wready_nxt;
	logic        arready_r, arready_nxt;
	logic        loop_act;

	// Read value and hit flag of one register index.
	function automatic logic [8:0] read_reg(input logic [9:0] idx,
	                                        input logic s, input logic o, input logic m,
	                                        input logic [1:0] md, input logic [1:0] sw,
	                                        input logic a, input logic d, input logic [1:0] b);
		logic [7:0] v;
		logic       hit;
		v   = 8'h00;
		hit = 1'b1;
		unique case (idx)
			{2'h0, video_cfg_pkg::IDX_TRANSMIT_MODE}:
			begin
				v[video_cfg_pkg::MAP_STRAP_BIT]    = s;
				v[video_cfg_pkg::MAP_OVERRIDE_BIT] = o;
				v[video_cfg_pkg::MAP_REG_BIT]      = m;
				v[video_cfg_pkg::OUT_MODE_LSB +: 2] = md;
			end
			{2'h0, video_cfg_pkg::IDX_SWING_CONTROL}:
				v[video_cfg_pkg::SWING_LSB +: 2] = sw;
			{2'h0, video_cfg_pkg::IDX_LOOP_SEL_A}:
				v[video_cfg_pkg::PORT_SEL_A_BIT] = a;
			{2'h0, video_cfg_pkg::IDX_LOOP_ENABLE}:
				v[video_cfg_pkg::DRIVER_EN_BIT] = d;
			{2'h0, video_cfg_pkg::IDX_LOOP_SEL_B}:
				v[video_cfg_pkg::PORT_SEL_B_LSB +: 2] = b;
			default:
				hit = 1'b0;
		endcase
		return {hit, v};
	endfunction

	// ****************************************************************
	// Write path: address and data are taken in either order, held
	// until both are present, then applied and answered together.
	// ****************************************************************
	always_comb
	begin
		logic       do_wr;
		logic [8:0] probe;
		do_wr       = 1'b0;
		probe       = 9'h000;
		aw_have_nxt = aw_have_r;
		aw_idx_nxt  = aw_idx_r;
		w_have_nxt  = w_have_r;
		w_data_nxt  = w_data_r;
		w_lane_nxt  = w_lane_r;
		bvalid_nxt  = bvalid_r;
		bresp_nxt   = bresp_r;
		ovr_nxt     = ovr_r;
		mapreg_nxt  = mapreg_r;
		mode_nxt    = mode_r;
		swing_nxt   = swing_r;
		sela_nxt    = sela_r;
		drv_nxt     = drv_r;
		selb_nxt    = selb_r;
		if (s_axi_awvalid && !aw_have_r && !bvalid_r)
		begin
			aw_have_nxt = 1'b1;
			aw_idx_nxt  = s_axi_awaddr[11:2];
		end
		if (s_axi_wvalid && !w_have_r && !bvalid_r)
		begin
			w_have_nxt = 1'b1;
			w_data_nxt = s_axi_wdata[7:0];
			w_lane_nxt = s_axi_wstrb[0];
		end
		if (bvalid_r && s_axi_bready)
			bvalid_nxt = 1'b0;
		if (aw_have_r && w_have_r && !bvalid_r)
		begin
			do_wr       = w_lane_r;
			aw_have_nxt = 1'b0;
			w_have_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			probe = read_reg(aw_idx_r, 1'b0, 1'b0, 1'b0, 2'h0, 2'h0, 1'b0, 1'b0, 2'h0);
			bresp_nxt = probe[8] ? video_cfg_pkg::RESP_OKAY : video_cfg_pkg::RESP_SLVERR;
		end
		// Only the defined fields take write data; other bits are dropped.
		if (do_wr)
		begin
			unique case (aw_idx_r)
				{2'h0, video_cfg_pkg::IDX_TRANSMIT_MODE}:
				begin
					ovr_nxt    = w_data_r[video_cfg_pkg::MAP_OVERRIDE_BIT];
					mapreg_nxt = w_data_r[video_cfg_pkg::MAP_REG_BIT];
					mode_nxt   = video_cfg_pkg::video_output_mode_t'(
					             w_data_r[video_cfg_pkg::OUT_MODE_LSB +: 2]);
				end
				{2'h0, video_cfg_pkg::IDX_SWING_CONTROL}:
					swing_nxt = w_data_r[video_cfg_pkg::SWING_LSB +: 2];
				{2'h0, video_cfg_pkg::IDX_LOOP_SEL_A}:
					sela_nxt = w_data_r[video_cfg_pkg::PORT_SEL_A_BIT];
				{2'h0, video_cfg_pkg::IDX_LOOP_ENABLE}:
					drv_nxt = w_data_r[video_cfg_pkg::DRIVER_EN_BIT];
				{2'h0, video_cfg_pkg::IDX_LOOP_SEL_B}:
					selb_nxt = w_data_r[video_cfg_pkg::PORT_SEL_B_LSB +: 2];
				default:
					ovr_nxt = ovr_r;
			endcase
		end
		// Readies are registered from the next slot state, so the pins come
		// straight from flops yet open in the same cycle as before.
		awready_nxt = !aw_have_nxt && !bvalid_nxt;
		wready_nxt  = !w_have_nxt && !bvalid_nxt;
		// The strap is caught on the first clocked cycle after reset release,
		// since a reset flop may only take a constant.
		load_nxt  = 1'b0;
		strap_nxt = strap_r;
		if (load_r)
		begin
			strap_nxt = strap_select_pin;
			mode_nxt  = video_cfg_pkg::video_output_mode_t'(strap_mode_pins);
		end
	end

	// ****************************************************************
	// Read path: one read at a time, answered the cycle after acceptance.
	// ****************************************************************
	always_comb
	begin
		logic [8:0] rd;
		rd         = read_reg(s_axi_araddr[11:2], strap_r, ovr_r, mapreg_r, mode_r,
		                      swing_r, sela_r, drv_r, selb_r);
		rvalid_nxt = rvalid_r;
		rdata_nxt  = rdata_r;
		rresp_nxt  = rresp_r;
		if (rvalid_r && s_axi_rready)
			rvalid_nxt = 1'b0;
		if (s_axi_arvalid && !rvalid_r)
		begin
			rvalid_nxt = 1'b1;
			rdata_nxt  = {24'h000000, rd[7:0]};
			rresp_nxt  = rd[8] ? video_cfg_pkg::RESP_OKAY : video_cfg_pkg::RESP_SLVERR;
		end
		arready_nxt = !rvalid_nxt;
	end

	// Steering outputs towards the datapath, registered.
	always_comb
	begin
		ctrl_nxt.video_output_mode     = mode_r;
		ctrl_nxt.colour_map_sel        = ovr_r ? mapreg_r : strap_r;
		ctrl_nxt.output_swing_setting  = swing_r;
		ctrl_nxt.loopthrough_driver_en = loop_act;
		ctrl_nxt.loopthrough_from_one  = sela_r;
	end

	// All state registers; reset values are constants only.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			strap_r   <= 1'b0;
			load_r    <= 1'b1;
			ovr_r     <= video_cfg_pkg::OVERRIDE_RST;
			mapreg_r  <= video_cfg_pkg::MAP_REG_RST;
			mode_r    <= video_cfg_pkg::MODE_DUAL;
			swing_r   <= video_cfg_pkg::SWING_RST;
			sela_r    <= video_cfg_pkg::SEL_A_RST;
			drv_r     <= video_cfg_pkg::DRIVER_EN_RST;
			selb_r    <= video_cfg_pkg::SEL_B_RST;
			ctrl_r    <= '0;
			aw_have_r <= 1'b0;
			aw_idx_r  <= 10'h000;
			w_have_r  <= 1'b0;
			w_data_r  <= 8'h00;
			w_lane_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= video_cfg_pkg::RESP_OKAY;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h00000000;
			rresp_r   <= video_cfg_pkg::RESP_OKAY;
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			arready_r <= 1'b1;
		end
		else
		begin
			strap_r   <= strap_nxt;
			load_r    <= load_nxt;
			ovr_r     <= ovr_nxt;
			mapreg_r  <= mapreg_nxt;
			mode_r    <= mode_nxt;
			swing_r   <= swing_nxt;
			sela_r    <= sela_nxt;
			drv_r     <= drv_nxt;
			selb_r    <= selb_nxt;
			ctrl_r    <= ctrl_nxt;
			aw_have_r <= aw_have_nxt;
			aw_idx_r  <= aw_idx_nxt;
			w_have_r  <= w_have_nxt;
			w_data_r  <= w_data_nxt;
			w_lane_r  <= w_lane_nxt;
			bvalid_r  <= bvalid_nxt;
			bresp_r   <= bresp_nxt;
			rvalid_r  <= rvalid_nxt;
			rdata_r   <= rdata_nxt;
			rresp_r   <= rresp_nxt;
			awready_r <= awready_nxt;
			wready_r  <= wready_nxt;
			arready_r <= arready_nxt;
		end
	end

	// ****************************************************************
	// Loop-through selector.
	// ****************************************************************
	loopthrough_mux u_loop
	(
		.aclk               (aclk),
		.aresetn            (aresetn),
		.driver_en          (drv_r),
		.port_sel_a         (sela_r),
		.port_sel_b         (selb_r),
		.receive_input_zero (receive_input_zero),
		.receive_input_one  (receive_input_one),
		.loopthrough_output (loopthrough_output),
		.loopthrough_active (loop_act)
	);

	// Ready is high when a channel slot is free and, for writes, no response is pending; every pin is a flop output.
	assign s_axi_awready = awready_r;
	assign s_axi_wready  = wready_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;
	assign video_ctrl    = ctrl_r;

endmodule

`default_nettype wire

// [logic/video_cfg_pkg.sv]
// Package of offsets, fields, reset values and carrier types for the video output config bank.
`default_nettype none

package video_cfg_pkg;

	// ****************************************************************
	// Register offsets. Some printed offsets are not multiples of four,
	// so each is an index and the byte address is four times it.
	// ****************************************************************
	localparam logic [7:0] IDX_TRANSMIT_MODE  = 8'h49;
	localparam logic [7:0] IDX_SWING_CONTROL  = 8'h4B;
	localparam logic [7:0] IDX_LOOP_SEL_A     = 8'h52;
	localparam logic [7:0] IDX_LOOP_ENABLE    = 8'h56;
	localparam logic [7:0] IDX_LOOP_SEL_B     = 8'h57;
	localparam int         ADDR_W             = 12;

	// ****************************************************************
	// Field positions.
	// ****************************************************************
	localparam int MAP_STRAP_BIT    = 7;
	localparam int MAP_OVERRIDE_BIT = 6;
	localparam int MAP_REG_BIT      = 5;
	localparam int OUT_MODE_LSB     = 0;
	localparam int SWING_LSB        = 0;
	localparam int PORT_SEL_A_BIT   = 7;
	localparam int DRIVER_EN_BIT    = 3;
	localparam int PORT_SEL_B_LSB   = 1;

	// ****************************************************************
	// Reset values and encodings.
	// ****************************************************************
	localparam logic       OVERRIDE_RST  = 1'h0;
	localparam logic       MAP_REG_RST   = 1'h0;
	localparam logic [1:0] SWING_RST     = 2'h0;
	localparam logic       SEL_A_RST     = 1'h0;
	localparam logic       DRIVER_EN_RST = 1'h0;
	localparam logic [1:0] SEL_B_RST     = 2'h0;
	localparam logic [1:0] SEL_B_PORT0   = 2'h1;
	localparam logic [1:0] SEL_B_PORT1   = 2'h2;
	localparam logic [1:0] RESP_OKAY     = 2'h0;
	localparam logic [1:0] RESP_SLVERR   = 2'h2;

	typedef enum logic [1:0] {
		MODE_DUAL,
		MODE_DUAL_SWAP,
		MODE_SINGLE,
		MODE_REPLICATE
	} video_output_mode_t;

	// Steering bundle towards the transmit and loop-through datapaths.
	typedef struct packed {
		video_output_mode_t video_output_mode;
		logic               colour_map_sel;
		logic [1:0]         output_swing_setting;
		logic               loopthrough_driver_en;
		logic               loopthrough_from_one;
	} video_ctrl_t;

endpackage

`default_nettype wire

// [logic/loopthrough_mux.sv]
// Loop-through source selector that re-emits one receive port's recovered data.
`timescale 1ns/100ps
`default_nettype none

module loopthrough_mux
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       driver_en,
	input  wire logic       port_sel_a,
	input  wire logic [1:0] port_sel_b,
	input  wire logic       receive_input_zero,
	input  wire logic       receive_input_one,
	output var  logic       loopthrough_output,
	output var  logic       loopthrough_active
);

	logic out_r;
	logic out_nxt;
	logic act_r;
	logic act_nxt;

	// Port choice follows select A; select B only gates with its legal codes.
	// A mismatch between the two fields is software's fault and is not repaired here.
	always_comb
	begin
		act_nxt = 1'b0;
		out_nxt = 1'b0;
		if (driver_en)
		begin
			unique case (port_sel_b)
				video_cfg_pkg::SEL_B_PORT0,
				video_cfg_pkg::SEL_B_PORT1:
				begin
					act_nxt = 1'b1;
					out_nxt = port_sel_a ? receive_input_one
					                     : receive_input_zero;
				end
				default:
				begin
					act_nxt = 1'b0;
					out_nxt = 1'b0;
				end
			endcase
		end
	end

	// Output and activity registers; idle low after reset.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			out_r <= 1'b0;
			act_r <= 1'b0;
		end
		else
		begin
			out_r <= out_nxt;
			act_r <= act_nxt;
		end
	end

	assign loopthrough_output = out_r;
	assign loopthrough_active = act_r;

endmodule

`default_nettype wire

// [verif/video_output_cfg_props.sv]
// Concurrent checks on the ports of the video output config bank.
`timescale 1ns/100ps
`default_nettype none

module video_output_cfg_props
(
	input wire logic                       aclk,
	input wire logic                       aresetn,
	input wire logic [11:0]                s_axi_araddr,
	input wire logic                       s_axi_arvalid,
	input wire logic                       s_axi_arready,
	input wire logic [31:0]                s_axi_rdata,
	input wire logic [1:0]                 s_axi_rresp,
	input wire logic                       s_axi_rvalid,
	input wire logic                       s_axi_bvalid,
	input wire logic                       strap_select_pin,
	input wire logic                       receive_input_zero,
	input wire logic                       receive_input_one,
	input wire video_cfg_pkg::video_ctrl_t video_ctrl,
	input wire logic                       loopthrough_output
);
	default clocking dcb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ******************************
	// Register read and write paths
	// ******************************
	// The strap stays put after reset, so the mode register must echo it.
	a_strap_read: assert property (
		s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h124
		|=> s_axi_rdata[7] == strap_select_pin && s_axi_rdata[4:2] == 3'h0)
		else $error("mode register read lost strap or reserved bits");
	a_unmapped_read: assert property (
		s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h000
		|=> s_axi_rdata == 32'h0 && s_axi_rresp == video_cfg_pkg::RESP_SLVERR)
		else $error("unmapped read not refused");
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late or address channel open");
	a_upper_zero: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	// Swing may only move as the tail of a write.
	a_swing_cause: assert property (
		$changed(video_ctrl.output_swing_setting) |-> s_axi_bvalid || $past(s_axi_bvalid))
		else $error("swing setting changed without a write");

	// ******************************
	// Loop-through steering
	// ******************************
	// The enable in the steering bundle lags the loop-through output by one
	// cycle, while the port bit is in step with it, so the output is judged a
	// cycle late against the data it was launched from.
	a_loop_idle: assert property (
		!video_ctrl.loopthrough_driver_en |-> $past(loopthrough_output) == 1'b0)
		else $error("loop-through driven while disabled");
	a_loop_zero: assert property (
		video_ctrl.loopthrough_driver_en && !$past(video_ctrl.loopthrough_from_one)
		|-> $past(loopthrough_output) == $past(receive_input_zero, 2))
		else $error("loop-through not following port zero");
	a_loop_one: assert property (
		video_ctrl.loopthrough_driver_en && $past(video_ctrl.loopthrough_from_one)
		|-> $past(loopthrough_output) == $past(receive_input_one, 2))
		else $error("loop-through not following port one");
endmodule

bind video_output_cfg video_output_cfg_props u_props (.aclk(aclk), .aresetn(aresetn),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_bvalid(s_axi_bvalid), .strap_select_pin(strap_select_pin),
	.receive_input_zero(receive_input_zero), .receive_input_one(receive_input_one),
	.video_ctrl(video_ctrl), .loopthrough_output(loopthrough_output));

`default_nettype wire

// [verif/test_video_output_cfg.sv]
// Self-checking bench for the video output config bank.
`timescale 1ns/100ps
`default_nettype none

module test_video_output_cfg;
	logic                       aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic                       s_axi_arvalid, s_axi_rready, strap_select_pin;
	logic                       receive_input_zero, receive_input_one, prev_zero, prev_one;
	logic                       s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic                       s_axi_rvalid, loopthrough_output, ok;
	logic [11:0]                s_axi_awaddr, s_axi_araddr;
	logic [31:0]                s_axi_wdata, s_axi_rdata;
	logic [3:0]                 s_axi_wstrb, cfg;
	logic [2:0]                 cnt;
	logic [1:0]                 s_axi_bresp, s_axi_rresp, strap_mode_pins;
	video_cfg_pkg::video_ctrl_t video_ctrl;
	int                         num_errors, compares;

	video_output_cfg dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .strap_select_pin, .strap_mode_pins,
		.receive_input_zero, .receive_input_one, .video_ctrl, .loopthrough_output);

	// Free-running clock.
	always #10 aclk = ~aclk;

	// Two receive streams at different rates, so a wrong port shows at once.
	always @(posedge aclk)
	begin
		cnt <= cnt + 3'h1;
		receive_input_zero <= cnt[0];
		receive_input_one <= cnt[1];
		prev_zero <= receive_input_zero;
		prev_one <= receive_input_one;
	end

	// ******************************
	// Bus and compare tasks
	// ******************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		begin
			compares++;
			if (got !== exp)
			begin
				num_errors++;
				$display("ERROR at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask

	// Address and data go out together; each is dropped once taken.
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
		int n;
		begin
			n = 0;
			@(posedge aclk);
			s_axi_awaddr <= a;
			s_axi_awvalid <= 1'b1;
			s_axi_wdata <= {24'h000000, d};
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			do
			begin
				@(posedge aclk);
				n++;
				if (s_axi_awready)
					s_axi_awvalid <= 1'b0;
				if (s_axi_wready)
					s_axi_wvalid <= 1'b0;
			end
			while (!s_axi_bvalid && n < 40);
			s_axi_bready <= 1'b0;
			chk(32'(n < 40), 32'h1);
			chk(32'(s_axi_bresp), 32'(er));
		end
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
		int n;
		begin
			n = 0;
			@(posedge aclk);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			do
			begin
				@(posedge aclk);
				n++;
				if (s_axi_arready)
					s_axi_arvalid <= 1'b0;
			end
			while (!s_axi_rvalid && n < 40);
			s_axi_rready <= 1'b0;
			chk(32'(n < 40), 32'h1);
			chk(s_axi_rdata, {24'h000000, e});
			chk(32'(s_axi_rresp), 32'(er));
		end
	endtask

	task finish_test;
		begin
			if (num_errors == 0 && compares > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask

	// Watchdog: the tests need well under a tenth of this span.
	initial
	begin
		#400000;
		num_errors++;
		finish_test();
	end

	// ******************************
	// Test sequence
	// ******************************
	initial
	begin
		{aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 6'h00;
		{s_axi_rready, receive_input_zero, receive_input_one, cnt} = 6'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
		s_axi_wstrb = 4'hF;
		strap_select_pin = 1'b1;
		strap_mode_pins = 2'h2;
		num_errors = 0;
		compares = 0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rd(12'h124, 8'h82, 2'h0);
		chk(32'(video_ctrl), 32'h50);
		wr(12'h124, 8'hFF, 2'h0);
		rd(12'h124, 8'hE3, 2'h0);
		chk(32'(video_ctrl), 32'h70);
		wr(12'h124, 8'h40, 2'h0);
		rd(12'h124, 8'hC0, 2'h0);
		chk(32'(video_ctrl), 32'h00);
		for (int m = 0; m < 4; m++)
		begin
			wr(12'h124, 8'(m), 2'h0);
			rd(12'h124, 8'h80 | 8'(m), 2'h0);
			chk(32'(video_ctrl.video_output_mode), 32'(m));
		end
		rd(12'h12C, 8'h00, 2'h0);
		for (int c = 0; c < 4; c++)
		begin
			wr(12'h12C, 8'hFC | 8'(c), 2'h0);
			rd(12'h12C, 8'(c), 2'h0);
			chk(32'(video_ctrl.output_swing_setting), 32'(c));
		end
		rd(12'h148, 8'h00, 2'h0);
		rd(12'h158, 8'h00, 2'h0);
		rd(12'h15C, 8'h00, 2'h0);
		wr(12'h148, 8'hFF, 2'h0);
		rd(12'h148, 8'h80, 2'h0);
		wr(12'h158, 8'hFF, 2'h0);
		rd(12'h158, 8'h08, 2'h0);
		wr(12'h15C, 8'hFF, 2'h0);
		rd(12'h15C, 8'h06, 2'h0);
		rd(12'h000, 8'h00, 2'h2);
		wr(12'h000, 8'hFF, 2'h2);
		// Each entry holds port select, driver enable and the two-bit second select.
		for (int i = 0; i < 5; i++)
		begin
			cfg = (i == 0) ? 4'h5 : (i == 1) ? 4'hE : (i == 2) ? 4'hA : (i == 3) ? 4'h4 : 4'hF;
			ok = cfg[2] && (cfg[1:0] == 2'h1 || cfg[1:0] == 2'h2);
			wr(12'h148, {cfg[3], 7'h00}, 2'h0);
			wr(12'h158, {4'h0, cfg[2], 3'h0}, 2'h0);
			wr(12'h15C, {5'h00, cfg[1:0], 1'b0}, 2'h0);
			repeat (2) @(posedge aclk);
			chk(32'(video_ctrl[1:0]), 32'({ok, cfg[3]}));
			repeat (4)
			begin
				@(posedge aclk);
				#1;
				chk(32'(loopthrough_output), 32'(ok && (cfg[3] ? prev_one : prev_zero)));
			end
		end
		// A second reset with the other strap levels must reload the mode field.
		@(posedge aclk);
		aresetn <= 1'b0;
		strap_select_pin <= 1'b0;
		strap_mode_pins <= 2'h1;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rd(12'h124, 8'h01, 2'h0);
		rd(12'h158, 8'h00, 2'h0);
		finish_test();
	end
endmodule

`default_nettype wire
